// *** rtl/data_memory_address_decode.sv ***
// Data memory address decoder, on-chip RAMs, aux registers and external bus
// Functional notes
// - Lower RAM reachable direct and indirect
// - Upper RAM reachable indirectly and by direct stack accesses
// - Direct non-stack above 7FH hits registers, indirect RAM
// - Registers and upper RAM physically separate
// - Select clear: moves below 300H use expanded RAM
// - Expanded RAM access leaves bus pins quiet
// - Select clear: pointer moves above 2FFH go off chip
// - Select clear: byte moves reach expanded 0-FFH only
// - Select set: every external move goes off chip
// - Byte move drives 8-bit address on port 0
// - Pointer move drives high byte, low multiplexed
// - Suppress clear: latch strobe at half rate
// - Suppress set: latch strobe only during moves
// - Memory control register resets to zero
// - Stack only in internal 256 bytes
// - Two pointers chosen by pointer select bit
// - Pointer control bit 2 reads zero
// - Bit 3 is a free user flag
// - Pointer control at A2H, resets zero
module data_memory_address_decode (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                req_valid,
    input  wire dmem_pkg::mem_req_s  req,
    input  wire logic [7:0]          addr_data_in,
    output logic [7:0]               rdata,
    output logic                     rdata_valid,
    output logic [15:0]              data_pointer,
    output dmem_pkg::target_e        last_target,
    output dmem_pkg::ext_bus_s       ext_bus
);
    import dmem_pkg::*;

    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_ADDRESS = 2'b01,
        BUS_DATA    = 2'b11,
        BUS_END     = 2'b10
    } bus_state_e;

    logic [7:0]   aux_memory_control;
    logic [7:0]   aux_pointer_control;
    logic [15:0]  first_data_pointer;
    logic [15:0]  second_data_pointer;
    logic         offchip_move_select;
    logic         latch_strobe_suppress;
    logic         pointer_select;
    logic         user_flag_b;
    target_e      next_target;
    logic [15:0]  eff_addr;
    logic         sfr_read_pending;
    logic [7:0]   sfr_rdata;
    logic [1:0]   read_src;
    logic [7:0]   int_rdata_lo;
    logic [7:0]   int_rdata_hi;
    logic [7:0]   exp_rdata;
    logic         half_tick;
    bus_state_e   bus_state;
    logic         bus_write;
    logic         bus_pointer;
    logic [15:0]  bus_addr;
    logic [7:0]   bus_wdata;

    assign offchip_move_select   = aux_memory_control[OFFCHIP_SELECT_BIT];
    assign latch_strobe_suppress = aux_memory_control[LATCH_SUPPRESS_BIT];
    assign pointer_select        = aux_pointer_control[POINTER_SELECT_BIT];
    assign user_flag_b           = aux_pointer_control[USER_FLAG_B_BIT];

    // Effective address: pointer moves use the selected pointer, byte moves 8 bits
    always_comb begin
        if (req.use_pointer) begin
            eff_addr = pointer_select ? second_data_pointer : first_data_pointer;
        end else if (req.kind == ACC_EXTERNAL) begin
            eff_addr = {8'h00, req.addr[7:0]};
        end else begin
            eff_addr = req.addr;
        end
    end

    // Target decode
    always_comb begin
        next_target = TGT_NONE;
        if (req_valid) begin
            unique case (req.kind)
                ACC_NONE: next_target = TGT_NONE;
                ACC_DIRECT: begin
                    if (req.stack || req.addr[7:0] <= LOWER_RAM_TOP) begin
                        next_target = (req.addr[7:0] <= LOWER_RAM_TOP) ? TGT_LOWER_RAM
                                                                       : TGT_UPPER_RAM;
                    end else begin
                        next_target = TGT_SFR;
                    end
                end
                ACC_INDIRECT: begin
                    next_target = (req.addr[7:0] <= LOWER_RAM_TOP) ? TGT_LOWER_RAM
                                                                   : TGT_UPPER_RAM;
                end
                ACC_EXTERNAL: begin
                    if (offchip_move_select) begin
                        next_target = TGT_OFFCHIP;
                    end else if (!req.use_pointer || eff_addr <= EXPANDED_RAM_TOP) begin
                        next_target = TGT_EXP_RAM;
                    end else begin
                        next_target = TGT_OFFCHIP;
                    end
                end
            endcase
        end
    end

    // Separate stores: lower, upper and expanded RAM; registers live in flops
    byte_store #(.DEPTH(INTERNAL_RAM_BYTES / 2), .AW(7)) lower_ram (
        .clock (clock),
        .we    (req.write && next_target == TGT_LOWER_RAM),
        .addr  (req.addr[6:0]),
        .wdata (req.wdata),
        .rdata (int_rdata_lo)
    );

    byte_store #(.DEPTH(INTERNAL_RAM_BYTES / 2), .AW(7)) upper_ram (
        .clock (clock),
        .we    (req.write && next_target == TGT_UPPER_RAM),
        .addr  (req.addr[6:0]),
        .wdata (req.wdata),
        .rdata (int_rdata_hi)
    );

    byte_store #(.DEPTH(EXPANDED_RAM_BYTES), .AW(10)) expanded_ram (
        .clock (clock),
        .we    (req.write && next_target == TGT_EXP_RAM),
        .addr  (eff_addr[9:0]),
        .wdata (req.wdata),
        .rdata (exp_rdata)
    );

    // Aux memory control register
    always_ff @(posedge clock) begin
        if (rst) begin
            aux_memory_control <= AUX_MEMORY_CONTROL_RESET;
        end else if (next_target == TGT_SFR && req.write
                     && req.addr[7:0] == AUX_MEMORY_CONTROL_ADDR) begin
            aux_memory_control <= req.wdata & AUX_MEMORY_CONTROL_MASK;
        end
    end

    // Aux pointer control register
    always_ff @(posedge clock) begin
        if (rst) begin
            aux_pointer_control <= AUX_POINTER_CONTROL_RESET;
        end else if (next_target == TGT_SFR && req.write
                     && req.addr[7:0] == AUX_POINTER_CONTROL_ADDR) begin
            aux_pointer_control <= req.wdata & AUX_POINTER_CONTROL_MASK;
        end
    end

    // Data pointers, loaded a byte at a time into the selected one
    always_ff @(posedge clock) begin
        if (rst) begin
            first_data_pointer  <= 16'h0000;
            second_data_pointer <= 16'h0000;
        end else if (req_valid && req.pointer_load) begin
            if (!pointer_select) begin
                if (req.pointer_high) begin
                    first_data_pointer[15:8] <= req.wdata;
                end else begin
                    first_data_pointer[7:0] <= req.wdata;
                end
            end else begin
                if (req.pointer_high) begin
                    second_data_pointer[15:8] <= req.wdata;
                end else begin
                    second_data_pointer[7:0] <= req.wdata;
                end
            end
        end
    end

    // Register read data
    always_comb begin
        if (req.addr[7:0] == AUX_MEMORY_CONTROL_ADDR) begin
            sfr_rdata = aux_memory_control;
        end else if (req.addr[7:0] == AUX_POINTER_CONTROL_ADDR) begin
            sfr_rdata = aux_pointer_control;
        end else begin
            sfr_rdata = 8'h00;
        end
    end

    // Read return: registers one cycle after the request, RAM two, off-chip reads three
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_valid      <= 1'b0;
            read_src         <= 2'h0;
            sfr_read_pending <= 1'b0;
            rdata            <= 8'h00;
        end else begin
            sfr_read_pending <= 1'b0;
            rdata_valid      <= 1'b0;
            if (req_valid && !req.write && next_target != TGT_OFFCHIP
                && next_target != TGT_NONE) begin
                rdata_valid <= (next_target == TGT_SFR);
                rdata       <= sfr_rdata;
                sfr_read_pending <= (next_target != TGT_SFR);
                unique case (next_target)
                    TGT_LOWER_RAM: read_src <= 2'h1;
                    TGT_UPPER_RAM: read_src <= 2'h2;
                    default:       read_src <= 2'h3;
                endcase
            end
            if (sfr_read_pending) begin
                rdata_valid <= 1'b1;
                rdata       <= (read_src == 2'h1) ? int_rdata_lo :
                               (read_src == 2'h2) ? int_rdata_hi : exp_rdata;
            end
            if (bus_state == BUS_DATA && !bus_write) begin
                rdata_valid <= 1'b1;
                rdata       <= addr_data_in;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            last_target  <= TGT_NONE;
            data_pointer <= 16'h0000;
        end else begin
            if (next_target != TGT_NONE) begin
                last_target <= next_target;
            end
            data_pointer <= pointer_select ? second_data_pointer : first_data_pointer;
        end
    end

    // Half-rate tick for the free-running latch strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            half_tick <= 1'b0;
        end else begin
            half_tick <= ~half_tick;
        end
    end

    // Off-chip bus sequencer: address, data, end
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_state   <= BUS_IDLE;
            bus_write   <= 1'b0;
            bus_pointer <= 1'b0;
            bus_addr    <= 16'h0000;
            bus_wdata   <= 8'h00;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (next_target == TGT_OFFCHIP) begin
                        bus_state   <= BUS_ADDRESS;
                        bus_write   <= req.write;
                        bus_pointer <= req.use_pointer;
                        bus_addr    <= eff_addr;
                        bus_wdata   <= req.wdata;
                    end
                end
                BUS_ADDRESS: bus_state <= BUS_DATA;
                BUS_DATA:    bus_state <= BUS_END;
                BUS_END:     bus_state <= BUS_IDLE;
            endcase
        end
    end

    // External pins, expanded and internal accesses never touch them
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_bus <= '{addr_data_out: 8'h00, addr_data_oe_n: 1'b1, addr_high: 8'h00,
                         read_strobe_n: 1'b1, write_strobe_n: 1'b1, latch_strobe: 1'b0};
        end else begin
            ext_bus.read_strobe_n  <= 1'b1;
            ext_bus.write_strobe_n <= 1'b1;
            ext_bus.addr_data_oe_n <= 1'b1;
            if (latch_strobe_suppress) begin
                ext_bus.latch_strobe <= (next_target == TGT_OFFCHIP && bus_state == BUS_IDLE)
                                        || (req_valid && req.code_move);
            end else begin
                ext_bus.latch_strobe <= half_tick;
            end
            if (next_target == TGT_OFFCHIP && bus_state == BUS_IDLE) begin
                ext_bus.addr_data_out  <= eff_addr[7:0];
                ext_bus.addr_data_oe_n <= 1'b0;
                if (req.use_pointer) begin
                    ext_bus.addr_high <= eff_addr[15:8];
                end
            end else if (bus_state == BUS_ADDRESS || bus_state == BUS_DATA) begin
                ext_bus.addr_data_out  <= bus_wdata;
                ext_bus.addr_data_oe_n <= ~bus_write;
                ext_bus.write_strobe_n <= ~bus_write;
                ext_bus.read_strobe_n  <= bus_write;
                if (bus_pointer) begin
                    ext_bus.addr_high <= bus_addr[15:8];
                end
            end
        end
    end
endmodule // data_memory_address_decode

// *** common/dmem_pkg.sv ***
// Package: data memory decode constants, types and register layout
package dmem_pkg;
    localparam logic [7:0]  AUX_MEMORY_CONTROL_ADDR  = 8'h8E;
    localparam logic [7:0]  AUX_POINTER_CONTROL_ADDR = 8'hA2;
    localparam logic [7:0]  AUX_MEMORY_CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  AUX_POINTER_CONTROL_RESET = 8'h00;
    localparam int          LATCH_SUPPRESS_BIT  = 0;
    localparam int          OFFCHIP_SELECT_BIT  = 1;
    localparam int          POINTER_SELECT_BIT  = 0;
    localparam int          USER_FLAG_B_BIT     = 3;
    localparam logic [7:0]  AUX_MEMORY_CONTROL_MASK  = 8'h03;
    localparam logic [7:0]  AUX_POINTER_CONTROL_MASK = 8'h09;
    localparam logic [7:0]  LOWER_RAM_TOP       = 8'h7F;
    localparam logic [15:0] EXPANDED_RAM_TOP    = 16'h02FF;
    localparam int          EXPANDED_RAM_BYTES  = 768;
    localparam int          INTERNAL_RAM_BYTES  = 256;

    typedef enum logic [1:0] {
        ACC_NONE     = 2'h0,
        ACC_DIRECT   = 2'h1,
        ACC_INDIRECT = 2'h2,
        ACC_EXTERNAL = 2'h3
    } access_kind_e;

    typedef enum logic [2:0] {
        TGT_NONE      = 3'h0,
        TGT_LOWER_RAM = 3'h1,
        TGT_UPPER_RAM = 3'h2,
        TGT_SFR       = 3'h3,
        TGT_EXP_RAM   = 3'h4,
        TGT_OFFCHIP   = 3'h5
    } target_e;

    typedef struct packed {
        access_kind_e kind;
        logic         write;
        logic         use_pointer;
        logic         stack;
        logic         code_move;
        logic         pointer_load;
        logic         pointer_high;
        logic [15:0]  addr;
        logic [7:0]   wdata;
    } mem_req_s;

    typedef struct packed {
        logic [7:0] addr_data_out;
        logic       addr_data_oe_n;
        logic [7:0] addr_high;
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic       latch_strobe;
    } ext_bus_s;
endpackage

// *** rtl/byte_store.sv ***
// Single-port byte memory with synchronous read
module byte_store #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clock,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic [7:0]         rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // byte_store

// *** bench/ext_mem_model.sv ***
// External data memory on the multiplexed address and data bus
module ext_mem_model (
    input  wire logic               clock,
    input  wire dmem_pkg::ext_bus_s bus,
    output logic [7:0]              addr_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import dmem_pkg::*;
    logic [7:0]  mem [65536];
    logic [15:0] adr = 16'h0000;
    logic [7:0]  last = 8'hA5;
    // Address latch: follows the bus address while both strobes are idle, holds it during a strobe
    always_ff @(posedge clock) begin
        if (bus.read_strobe_n && bus.write_strobe_n)
            adr <= {bus.addr_high, bus.addr_data_out};
        if (!bus.write_strobe_n)
            mem[adr] <= bus.addr_data_out;
        last <= addr_data_in;
    end
    // Released bus shows the inverse of the last value, never a stale copy
    always_comb begin
        addr_data_in = !bus.read_strobe_n ? mem[adr] : ~last;
    end
endmodule // ext_mem_model

// *** bench/data_memory_address_decode_checker.sv ***
// Checker: timing relations at the data memory decoder ports
module data_memory_address_decode_checker (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               req_valid,
    input wire dmem_pkg::mem_req_s req,
    input wire logic [7:0]         addr_data_in,
    input wire logic [7:0]         rdata,
    input wire logic               rdata_valid,
    input wire logic [15:0]        data_pointer,
    input wire dmem_pkg::target_e  last_target,
    input wire dmem_pkg::ext_bus_s ext_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    import dmem_pkg::*;
    logic       sel, supp, xt, off, loc, rr, cw;
    logic [1:0] cnt, qc, up;
    logic [7:0] ba;
    assign ba  = req.addr[7:0];
    assign xt  = req_valid && req.kind == ACC_EXTERNAL;
    assign off = xt && cnt == 2'h0 && (sel || req.use_pointer && data_pointer > EXPANDED_RAM_TOP);
    assign loc = xt && cnt == 2'h0 && !off;
    assign rr  = req_valid && req.kind == ACC_DIRECT && !req.write;
    assign cw  = req_valid && req.kind == ACC_DIRECT && req.write
                 && ba == AUX_MEMORY_CONTROL_ADDR;
    // Shadow of the memory control bits
    always_ff @(posedge clock) begin
        if (rst) begin
            sel  <= 1'b0;
            supp <= 1'b0;
        end else if (cw) begin
            sel  <= req.wdata[OFFCHIP_SELECT_BIT];
            supp <= req.wdata[LATCH_SUPPRESS_BIT];
        end
    end
    // Bus busy, settle and post-reset counters
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt <= 2'h0;
            qc  <= 2'h0;
            up  <= 2'h0;
        end else begin
            cnt <= (off || req_valid && req.code_move) ? 2'h3 : cnt - {1'b0, cnt != 2'h0};
            qc  <= cw ? 2'h0 : qc + {1'b0, qc != 2'h3};
            up  <= up + {1'b0, up != 2'h3};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff rst;
    sequence s_quiet;
        (ext_bus.read_strobe_n && ext_bus.write_strobe_n && ext_bus.addr_data_oe_n) [*4];
    endsequence
    sequence s_wr;
        ext_bus.write_strobe_n ##1 !ext_bus.write_strobe_n [*2] ##1 ext_bus.write_strobe_n;
    endsequence
    sequence s_rd;
        ext_bus.read_strobe_n ##1 (!ext_bus.read_strobe_n && ext_bus.addr_data_oe_n) [*2]
            ##1 ext_bus.read_strobe_n;
    endsequence
    a_reset_idle: assert property ($fell(rst) |-> ext_bus.read_strobe_n
        && ext_bus.write_strobe_n && ext_bus.addr_data_oe_n && !rdata_valid)
        else $error("bus not idle after reset");
    a_local_quiet: assert property (loc |=> s_quiet)
        else $error("bus active on expanded access");
    a_byte_local: assert property (loc && !req.use_pointer && !sel |=> s_quiet)
        else $error("byte move left the chip");
    a_write_cycle: assert property (off && req.write |=> s_wr)
        else $error("write strobe pulse wrong");
    a_read_cycle: assert property (off && !req.write |=> s_rd)
        else $error("read strobe pulse wrong");
    a_read_answer: assert property (off && !req.write |-> ##[3:4] rdata_valid)
        else $error("off-chip read not answered");
    a_pointer_addr: assert property (off && req.use_pointer |=> !ext_bus.addr_data_oe_n
        && {ext_bus.addr_high, ext_bus.addr_data_out} == $past(data_pointer))
        else $error("pointer address wrong");
    a_byte_addr: assert property (off && !req.use_pointer |=> !ext_bus.addr_data_oe_n
        && ext_bus.addr_data_out == $past(ba))
        else $error("byte address wrong");
    a_latch_rate: assert property (up == 2'h3 && qc == 2'h3 && !supp
        |-> ext_bus.latch_strobe != $past(ext_bus.latch_strobe))
        else $error("latch strobe not toggling");
    a_latch_quiet: assert property (supp && qc == 2'h3 && cnt == 2'h0
        |-> !ext_bus.latch_strobe)
        else $error("latch strobe while suppressed");
    a_ptr_reserved: assert property (rr && ba == AUX_POINTER_CONTROL_ADDR
        |-> ##[1:2] rdata_valid && (rdata & ~AUX_POINTER_CONTROL_MASK) == 8'h00)
        else $error("pointer control reserved bits set");
    a_mem_reserved: assert property (rr && ba == AUX_MEMORY_CONTROL_ADDR
        |-> ##[1:2] rdata_valid && (rdata & ~AUX_MEMORY_CONTROL_MASK) == 8'h00)
        else $error("memory control reserved bits set");
endmodule // data_memory_address_decode_checker
bind data_memory_address_decode data_memory_address_decode_checker checker_u (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .addr_data_in(addr_data_in), .rdata(rdata), .rdata_valid(rdata_valid),
    .data_pointer(data_pointer), .last_target(last_target), .ext_bus(ext_bus));

// *** bench/data_memory_address_decode_test.sv ***
// Testbench: data memory decoder with external memory model
module data_memory_address_decode_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dmem_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    mem_req_s    req = '0;
    logic [7:0]  addr_data_in, rdata;
    logic        rdata_valid;
    logic [15:0] data_pointer, got, highs;
    target_e     last_target;
    ext_bus_s    ext_bus;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #25 clock = ~clock;
    data_memory_address_decode dut_u (.clock(clock), .rst(rst), .req_valid(req_valid),
        .req(req), .addr_data_in(addr_data_in), .rdata(rdata), .rdata_valid(rdata_valid),
        .data_pointer(data_pointer), .last_target(last_target), .ext_bus(ext_bus));
    ext_mem_model model_u (.clock(clock), .bus(ext_bus), .addr_data_in(addr_data_in));
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_tgt(target_e g, target_e e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %0t target %0d expected %0d", $time, g, e);
        end
    endtask
    // f holds stack, code move, pointer load, pointer high
    task automatic go(access_kind_e k, logic w, logic p, logic [15:0] a, logic [7:0] d,
                      logic [3:0] f);
        @(negedge clock);
        req_valid = 1'b1;
        req = '{k, w, p, f[3], f[2], f[1], f[0], a, d};
        @(negedge clock);
        req_valid = 1'b0;
    endtask
    task automatic rd(access_kind_e k, logic p, logic [15:0] a);
        int i;
        go(k, 1'b0, p, a, 8'h00, 4'h0);
        for (i = 0; i < 8 && rdata_valid !== 1'b1; i++)
            @(negedge clock);
        got = rdata_valid === 1'b1 ? {8'h00, rdata} : 16'hXXXX;
        repeat (3) @(negedge clock);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        go(ACC_DIRECT, 1'b1, 1'b0, {8'h00, a}, d, 4'h0);
    endtask
    task automatic xw(logic p, logic [15:0] a, logic [7:0] d);
        go(ACC_EXTERNAL, 1'b1, p, a, d, 4'h0);
        repeat (4) @(negedge clock);
    endtask
    task automatic ld(logic [15:0] v);
        go(ACC_NONE, 1'b0, 1'b0, 16'h0000, v[15:8], 4'h3);
        go(ACC_NONE, 1'b0, 1'b0, 16'h0000, v[7:0], 4'h2);
    endtask
    task automatic tg(target_e e);
        @(negedge clock);
        chk_tgt(last_target, e);
    endtask
    // Counts latch strobe highs over 20 cycles, sampled at falling edges
    task automatic count_highs(output logic [15:0] n);
        n = 16'h0000;
        repeat (20) begin
            @(negedge clock);
            n = n + {15'h0000, ext_bus.latch_strobe === 1'b1};
        end
    endtask
    task automatic t_reset;
        rd(ACC_DIRECT, 1'b0, 16'h008E);
        chk(got, {8'h00, AUX_MEMORY_CONTROL_RESET});
        rd(ACC_DIRECT, 1'b0, 16'h00A2);
        chk(got, {8'h00, AUX_POINTER_CONTROL_RESET});
        chk(data_pointer, 16'h0000);
    endtask
    task automatic t_regs;
        wr(8'h8E, 8'hFF);
        rd(ACC_DIRECT, 1'b0, 16'h008E);
        chk(got, 16'h0003);
        wr(8'hA2, 8'hFF);
        rd(ACC_DIRECT, 1'b0, 16'h00A2);
        chk(got, 16'h0009);
        wr(8'hA2, 8'h08);
        rd(ACC_DIRECT, 1'b0, 16'h00A2);
        chk(got, 16'h0008);
        wr(8'hA2, 8'h09);
        rd(ACC_DIRECT, 1'b0, 16'h00A2);
        chk(got, 16'h0009);
        wr(8'hA2, 8'h0A);
        rd(ACC_DIRECT, 1'b0, 16'h00A2);
        chk(got, 16'h0008);
        wr(8'h8E, 8'h00);
        wr(8'hA2, 8'h00);
    endtask
    task automatic t_internal;
        go(ACC_DIRECT, 1'b1, 1'b0, 16'h0030, 8'h11, 4'h0);
        tg(TGT_LOWER_RAM);
        rd(ACC_INDIRECT, 1'b0, 16'h0030);
        chk(got, 16'h0011);
        go(ACC_INDIRECT, 1'b1, 1'b0, 16'h0090, 8'h22, 4'h0);
        tg(TGT_UPPER_RAM);
        go(ACC_DIRECT, 1'b1, 1'b0, 16'h0090, 8'h33, 4'h0);
        tg(TGT_SFR);
        rd(ACC_INDIRECT, 1'b0, 16'h0090);
        chk(got, 16'h0022);
        go(ACC_DIRECT, 1'b1, 1'b0, 16'h00C0, 8'h44, 4'h8);
        tg(TGT_UPPER_RAM);
        rd(ACC_INDIRECT, 1'b0, 16'h00C0);
        chk(got, 16'h0044);
    endtask
    task automatic t_pointers;
        ld(16'h1234);
        wr(8'hA2, 8'h01);
        ld(16'h5678);
        @(negedge clock);
        chk(data_pointer, 16'h5678);
        wr(8'hA2, 8'h00);
        repeat (2) @(negedge clock);
        chk(data_pointer, 16'h1234);
    endtask
    task automatic t_expanded;
        ld(16'h02A0);
        xw(1'b1, 16'h0000, 8'h5A);
        tg(TGT_EXP_RAM);
        ld(16'h01A0);
        xw(1'b1, 16'h0000, 8'h77);
        xw(1'b0, 16'h01A0, 8'h6B);
        rd(ACC_EXTERNAL, 1'b1, 16'h0000);
        chk(got, 16'h0077);
        ld(16'h00A0);
        rd(ACC_EXTERNAL, 1'b1, 16'h0000);
        chk(got, 16'h006B);
        ld(16'h02A0);
        rd(ACC_EXTERNAL, 1'b1, 16'h0000);
        chk(got, 16'h005A);
    endtask
    task automatic t_offchip;
        logic [15:0] a;
        for (int n = 0; n < 2; n++) begin
            a = n == 0 ? 16'h0300 : 16'hFFFF;
            ld(a);
            xw(1'b1, 16'h0000, a[7:0] ^ 8'h3C);
            tg(TGT_OFFCHIP);
            chk({8'h00, model_u.mem[a]}, {8'h00, a[7:0] ^ 8'h3C});
            rd(ACC_EXTERNAL, 1'b1, 16'h0000);
            chk(got, {8'h00, a[7:0] ^ 8'h3C});
        end
    endtask
    task automatic t_sel_set;
        wr(8'h8E, 8'h02);
        ld(16'h0005);
        xw(1'b1, 16'h0000, 8'hC5);
        chk({8'h00, model_u.mem[16'h0005]}, 16'h00C5);
        rd(ACC_EXTERNAL, 1'b1, 16'h0000);
        chk(got, 16'h00C5);
        xw(1'b0, 16'h0042, 8'h9E);
        rd(ACC_EXTERNAL, 1'b0, 16'h0042);
        chk(got, 16'h009E);
        wr(8'h8E, 8'h00);
    endtask
    task automatic t_latch;
        wr(8'h8E, 8'h01);
        repeat (4) @(negedge clock);
        count_highs(highs);
        chk(highs, 16'h0000);
        go(ACC_NONE, 1'b0, 1'b0, 16'h0000, 8'h00, 4'h4);
        chk({15'h0000, ext_bus.latch_strobe}, 16'h0001);
        wr(8'h8E, 8'h00);
        repeat (4) @(negedge clock);
        count_highs(highs);
        chk(highs, 16'h000A);
    endtask
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_reset;
        t_regs;
        t_internal;
        t_pointers;
        t_expanded;
        t_offchip;
        t_sel_set;
        t_latch;
        complete_run;
    end
endmodule // data_memory_address_decode_test
